//--- core/sbr_pkg.sv
`default_nettype none
package sbr_pkg;
	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_MSB  = 35;
	localparam int ADDR_LSB  = 3;
	localparam int PAR_SPLIT = 24;
	localparam int A20_POS   = 20;
	localparam int TYPE_W    = 32;
	localparam int RATIO_W   = 4;

	typedef logic [ADDR_MSB:ADDR_LSB] sbr_addr_t;
	typedef enum logic [1:0] {RQ_IDLE, RQ_ADDR, RQ_TYPE} sbr_req_st_t;

	// ------------------------------------------------------------
	// Register map (APB, byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_ADDR_LO = 8'h08;
	localparam logic [7:0] REG_ADDR_HI = 8'h0c;
	localparam logic [7:0] REG_TYPE    = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	localparam logic [7:0] REG_MASK    = 8'h18;
	localparam logic [7:0] REG_CFG_LO  = 8'h1c;
	localparam logic [7:0] REG_CFG_HI  = 8'h20;

	localparam int CTRL_W        = 3;
	localparam int CTRL_BUS_ERROR_N_EN  = 0;
	localparam int CTRL_BUS_ERROR_N_IER = 1;
	localparam int CTRL_BUS_ERROR_N_REQ = 2;
	localparam int CMD_GO        = 0;
	localparam int STATUS_W      = 4;
	localparam int ST_DONE       = 0;
	localparam int ST_PARERR     = 1;
	localparam int ST_CFG        = 2;
	localparam int ST_SEEN       = 3;
	localparam int HI_W          = 4;
	localparam int RATIO_POS     = 8;

	localparam logic [CTRL_W-1:0]   CTRL_RST   = 3'h0;
	localparam logic [STATUS_W-1:0] STATUS_RST = 4'h0;

	// ------------------------------------------------------------
	// Timing (bus clock cycles)
	// ------------------------------------------------------------
	localparam logic [4:0] RST_HOLD_CYCLES = 5'h10;
	localparam logic [1:0] TARGET_READY_N_DELAY      = 2'h2;

	function automatic logic par_high(input sbr_addr_t a);
		return ^a[ADDR_MSB:PAR_SPLIT];
	endfunction

	function automatic logic par_low(input sbr_addr_t a);
		return ^a[PAR_SPLIT-1:ADDR_LSB];
	endfunction

	function automatic sbr_addr_t mask_a20(input sbr_addr_t a, input logic m);
		sbr_addr_t r;
		r = a;
		if (m) begin
			r[A20_POS] = 1'b0;
		end
		return r;
	endfunction
endpackage
`default_nettype wire

//--- core/sbr_bus_if.sv
`default_nettype none
interface sbr_bus_if;
	import sbr_pkg::*;

	// ------------------------------------------------------------
	// Per-party drive, low enable means driving
	// ------------------------------------------------------------
	sbr_addr_t  dev_addr_o, cs_addr_o, addr_n;
	logic       dev_req_oe_n, cs_req_oe_n;
	logic       dev_strobe_o, cs_strobe_o, addr_strobe_n;
	logic       dev_par_lo_o, cs_par_lo_o, addr_parity_low_n;
	logic       dev_par_hi_o, cs_par_hi_o, addr_parity_high_n;
	logic       dev_bus_error_n_o, dev_bus_error_n_oe_n, cs_bus_error_n_o, cs_bus_error_n_oe_n, bus_error_n;
	logic       bus_reset_n;
	logic       addr_bit20_mask_n;
	logic       ignore_numeric_error_n;
	logic [1:0] local_irq_inputs;
	logic       target_ready_n;

	// Wired resolution of the active-low shared lines
	assign addr_n = (dev_req_oe_n ? '1 : dev_addr_o) & (cs_req_oe_n ? '1 : cs_addr_o);
	assign addr_strobe_n = (dev_req_oe_n | dev_strobe_o) & (cs_req_oe_n | cs_strobe_o);
	assign addr_parity_low_n = (dev_req_oe_n | dev_par_lo_o) & (cs_req_oe_n | cs_par_lo_o);
	assign addr_parity_high_n = (dev_req_oe_n | dev_par_hi_o) & (cs_req_oe_n | cs_par_hi_o);
	assign bus_error_n = (dev_bus_error_n_oe_n | dev_bus_error_n_o) & (cs_bus_error_n_oe_n | cs_bus_error_n_o);

	modport dev (
		output dev_addr_o, dev_req_oe_n, dev_strobe_o, dev_par_lo_o, dev_par_hi_o,
		output dev_bus_error_n_o, dev_bus_error_n_oe_n,
		input  addr_n, addr_strobe_n, addr_parity_low_n, addr_parity_high_n,
		input  bus_reset_n, addr_bit20_mask_n, ignore_numeric_error_n, local_irq_inputs
	);

	modport cs (
		output cs_addr_o, cs_req_oe_n, cs_strobe_o, cs_par_lo_o, cs_par_hi_o,
		output cs_bus_error_n_o, cs_bus_error_n_oe_n,
		output bus_reset_n, addr_bit20_mask_n, ignore_numeric_error_n, local_irq_inputs,
		output target_ready_n,
		input  addr_n, addr_strobe_n, addr_parity_low_n, addr_parity_high_n, bus_error_n
	);
endinterface
`default_nettype wire

//--- core/sbr_proc_end.sv
// Summary of operation
// - Address with strobe, type info without it
// - Upper and lower parity cover address groups
// - Address lines latched as config on reset release
// - Mask forces bit 20 low on device request addresses and cache lookups; system-side requests are not masked
// - Mask asserted only in real mode, or in reset when strap_ratio[3] is set
// - Mask valid with target ready of write
// - Ratio straps sampled in reset, frozen after
// - System releases strap pins after reset
// - Strobe in clock with valid address
// - Strobe starts checking of every transaction; the device does not check its own requests
// - Everything launched and sampled on rising edge
// - Bus error reports unrecoverable non-protocol error
// - Device ignores bus error from others
// - Bus error options set by configuration
`default_nettype none
module sbr_proc_end
	import sbr_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	sbr_bus_if.dev                   bus,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	input  wire logic                internal_err,
	input  wire logic                req_error,
	input  wire sbr_addr_t           lookup_addr_in,
	output sbr_addr_t                lookup_addr,
	output logic      [RATIO_W-1:0]  core_ratio,
	output logic                     bus_in_reset
);
	// ------------------------------------------------------------
	// Reset, straps and mask input
	// ------------------------------------------------------------
	logic                 bus_rst_act;
	logic                 rst_was;
	logic                 cfg_rise;
	logic                 cfg_done;
	logic                 mask_meta;
	logic                 mask_sync;
	sbr_addr_t            cfg;

	assign bus_rst_act = ~bus.bus_reset_n;
	assign cfg_rise    = rst_was & ~bus_rst_act;

	// Mask pin is asynchronous to the bus clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_meta <= 1'b0;
			mask_sync <= 1'b0;
		end else begin
			mask_meta <= ~bus.addr_bit20_mask_n;
			mask_sync <= mask_meta;
		end
	end

	// Sampled every reset cycle; the last sample before release is kept
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg        <= '0;
			core_ratio <= '0;
		end else if (bus_rst_act) begin
			cfg        <= ~bus.addr_n;
			core_ratio <= {mask_sync, ~bus.ignore_numeric_error_n, ~bus.local_irq_inputs};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_was      <= 1'b0;
			cfg_done     <= 1'b0;
			bus_in_reset <= 1'b0;
		end else begin
			rst_was      <= bus_rst_act;
			bus_in_reset <= bus_rst_act;
			if (bus_rst_act) begin
				cfg_done <= 1'b0;
			end else if (cfg_rise) begin
				cfg_done <= 1'b1;
			end
		end
	end

	// Cache lookups see the same masked address as the bus
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lookup_addr <= '0;
		end else begin
			lookup_addr <= mask_a20(lookup_addr_in, mask_sync);
		end
	end

	// ------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------
	logic                 setup;
	logic                 access;
	logic                 wr;
	logic                 known;
	logic [CTRL_W-1:0]    ctrl;
	sbr_addr_t            req_addr;
	logic [TYPE_W-1:0]    req_type;
	logic [STATUS_W-1:0]  status;
	logic [STATUS_W-1:0]  irq_mask;
	logic [STATUS_W-1:0]  st_set;
	logic [STATUS_W-1:0]  st_clr;
	logic [31:0]          rd_mux;
	logic                 go_pend;
	sbr_req_st_t          st;

	assign setup  = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr     = access & pwrite & ~pslverr;

	always_comb begin
		known  = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			REG_CTRL:    rd_mux[CTRL_W-1:0] = ctrl;
			REG_CMD:     rd_mux[CMD_GO] = go_pend | (st != RQ_IDLE);
			REG_ADDR_LO: rd_mux[31:ADDR_LSB] = req_addr[31:ADDR_LSB];
			REG_ADDR_HI: rd_mux[HI_W-1:0] = req_addr[ADDR_MSB:32];
			REG_TYPE:    rd_mux = req_type;
			REG_STATUS:  rd_mux[STATUS_W-1:0] = status;
			REG_MASK:    rd_mux[STATUS_W-1:0] = irq_mask;
			REG_CFG_LO:  rd_mux[31:ADDR_LSB] = cfg[31:ADDR_LSB];
			REG_CFG_HI:  rd_mux = {16'h0000, 4'h0, core_ratio, 4'h0, cfg[ADDR_MSB:32]};
			default:     known = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~known;
			prdata  <= (setup & ~pwrite) ? rd_mux : '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl     <= CTRL_RST;
			req_addr <= '0;
			req_type <= '0;
			irq_mask <= '0;
		end else if (wr) begin
			if (paddr == REG_CTRL) begin
				ctrl <= pwdata[CTRL_W-1:0];
			end
			if (paddr == REG_ADDR_LO) begin
				req_addr[31:ADDR_LSB] <= pwdata[31:ADDR_LSB];
			end
			if (paddr == REG_ADDR_HI) begin
				req_addr[ADDR_MSB:32] <= pwdata[HI_W-1:0];
			end
			if (paddr == REG_TYPE) begin
				req_type <= pwdata;
			end
			if (paddr == REG_MASK) begin
				irq_mask <= pwdata[STATUS_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Status, clear on read, set wins
	// ------------------------------------------------------------
	logic                 observe;
	logic                 par_err;
	sbr_addr_t            seen_addr;

	assign seen_addr = ~bus.addr_n;
	assign observe   = ~bus.addr_strobe_n & (st != RQ_ADDR);
	assign par_err   = observe & ((par_high(seen_addr) != ~bus.addr_parity_high_n)
		| (par_low(seen_addr) != ~bus.addr_parity_low_n));

	always_comb begin
		st_set             = '0;
		st_set[ST_DONE]    = (st == RQ_TYPE);
		st_set[ST_PARERR]  = par_err;
		st_set[ST_CFG]     = cfg_rise;
		st_set[ST_SEEN]    = observe;
		st_clr = (access & ~pwrite & (paddr == REG_STATUS)) ? prdata[STATUS_W-1:0] : '0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			status <= STATUS_RST;
			irq    <= 1'b0;
		end else begin
			status <= (status & ~st_clr) | st_set;
			irq    <= |(status & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// Request phase driver
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			go_pend <= 1'b0;
		end else if (wr && paddr == REG_CMD && pwdata[CMD_GO]) begin
			go_pend <= 1'b1;
		end else if (st == RQ_ADDR) begin
			go_pend <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || bus_rst_act) begin
			st               <= RQ_IDLE;
			bus.dev_req_oe_n <= 1'b1;
			bus.dev_strobe_o <= 1'b1;
			bus.dev_addr_o   <= '1;
			bus.dev_par_lo_o <= 1'b1;
			bus.dev_par_hi_o <= 1'b1;
		end else begin
			unique case (st)
				RQ_IDLE: begin
					if (go_pend && cfg_done && bus.addr_strobe_n) begin
						st               <= RQ_ADDR;
						bus.dev_req_oe_n <= 1'b0;
						bus.dev_strobe_o <= 1'b0;
						bus.dev_addr_o   <= ~mask_a20(req_addr, mask_sync);
						bus.dev_par_hi_o <= ~par_high(mask_a20(req_addr, mask_sync));
						bus.dev_par_lo_o <= ~par_low(mask_a20(req_addr, mask_sync));
					end
				end
				RQ_ADDR: begin
					st               <= RQ_TYPE;
					bus.dev_strobe_o <= 1'b1;
					bus.dev_addr_o   <= ~{1'b0, req_type};
					bus.dev_par_hi_o <= 1'b1;
					bus.dev_par_lo_o <= 1'b1;
				end
				RQ_TYPE: begin
					st               <= RQ_IDLE;
					bus.dev_req_oe_n <= 1'b1;
					bus.dev_addr_o   <= '1;
				end
			endcase
		end
	end

	// Bus error is only ever driven, never sampled from the bus
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus.dev_bus_error_n_o    <= 1'b1;
			bus.dev_bus_error_n_oe_n <= 1'b1;
		end else begin
			bus.dev_bus_error_n_o    <= 1'b0;
			bus.dev_bus_error_n_oe_n <= ~(ctrl[CTRL_BUS_ERROR_N_EN] & (par_err
				| (ctrl[CTRL_BUS_ERROR_N_IER] & internal_err)
				| (ctrl[CTRL_BUS_ERROR_N_REQ] & req_error)));
		end
	end
endmodule
`default_nettype wire

//--- core/sbr_cs_end.sv
`default_nettype none
module sbr_cs_end
	import sbr_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	sbr_bus_if.cs                    bus,
	input  wire sbr_addr_t           strap_cfg,
	input  wire logic [RATIO_W-1:0]  strap_ratio,
	input  wire logic                real_mode,
	input  wire logic                a20_gate,
	input  wire logic                bus_error_n_enable,
	input  wire logic                issue,
	input  wire sbr_addr_t           issue_addr,
	input  wire logic [TYPE_W-1:0]   issue_type,
	output logic                     issue_ready,
	output logic                     txn_valid,
	output sbr_addr_t                txn_addr,
	output logic [TYPE_W-1:0]        txn_type,
	output logic                     txn_par_err,
	output logic                     bus_error_seen
);
	// ------------------------------------------------------------
	// Bus reset with strap drive
	// ------------------------------------------------------------
	logic [4:0]   hold_cnt;
	logic         in_rst;
	sbr_req_st_t  st;

	assign in_rst = ~bus.bus_reset_n;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_cnt                   <= '0;
			bus.bus_reset_n            <= 1'b0;
			bus.ignore_numeric_error_n <= 1'b1;
			bus.local_irq_inputs       <= 2'h3;
		end else if (hold_cnt != RST_HOLD_CYCLES) begin
			hold_cnt                   <= hold_cnt + 5'h01;
			bus.ignore_numeric_error_n <= ~strap_ratio[2];
			bus.local_irq_inputs       <= ~strap_ratio[1:0];
		end else begin
			bus.bus_reset_n            <= 1'b1;
			bus.ignore_numeric_error_n <= 1'b1;
			bus.local_irq_inputs       <= 2'h3;
		end
	end

	// ------------------------------------------------------------
	// Observe device requests, target ready, mask update
	// ------------------------------------------------------------
	logic         obs;
	logic         obs_d;
	logic         perr;
	logic [1:0]   target_ready_n_wait;
	sbr_addr_t    seen;

	assign seen = ~bus.addr_n;
	assign obs  = ~bus.addr_strobe_n & (st != RQ_ADDR);
	assign perr = obs & ((par_high(seen) != ~bus.addr_parity_high_n)
		| (par_low(seen) != ~bus.addr_parity_low_n));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			obs_d          <= 1'b0;
			txn_valid      <= 1'b0;
			txn_addr       <= '0;
			txn_type       <= '0;
			txn_par_err    <= 1'b0;
			bus_error_seen <= 1'b0;
		end else begin
			obs_d          <= obs;
			txn_valid      <= obs_d;
			bus_error_seen <= ~bus.bus_error_n;
			if (obs) begin
				txn_addr    <= seen;
				txn_par_err <= perr;
			end
			if (obs_d) begin
				txn_type <= seen[ADDR_LSB+TYPE_W-1:ADDR_LSB];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			target_ready_n_wait             <= '0;
			bus.target_ready_n    <= 1'b1;
			bus.addr_bit20_mask_n <= 1'b1;
		end else if (in_rst) begin
			target_ready_n_wait             <= '0;
			bus.target_ready_n    <= 1'b1;
			bus.addr_bit20_mask_n <= ~strap_ratio[3];
		end else begin
			bus.target_ready_n <= 1'b1;
			if (obs) begin
				target_ready_n_wait <= TARGET_READY_N_DELAY;
			end else if (target_ready_n_wait != 2'h0) begin
				target_ready_n_wait <= target_ready_n_wait - 2'h1;
			end
			if (target_ready_n_wait == 2'h1) begin
				bus.target_ready_n    <= 1'b0;
				bus.addr_bit20_mask_n <= ~(real_mode & a20_gate);
			end else if (hold_cnt == RST_HOLD_CYCLES && bus.addr_bit20_mask_n == 1'b0
				&& !real_mode) begin
				bus.addr_bit20_mask_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus.cs_bus_error_n_o    <= 1'b1;
			bus.cs_bus_error_n_oe_n <= 1'b1;
		end else begin
			bus.cs_bus_error_n_o    <= 1'b0;
			bus.cs_bus_error_n_oe_n <= ~(bus_error_n_enable & perr);
		end
	end

	// ------------------------------------------------------------
	// Own requests; straps ride the address lines during reset
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst || in_rst) begin
			st              <= RQ_IDLE;
			issue_ready     <= 1'b0;
			bus.cs_req_oe_n <= 1'b0;
			bus.cs_addr_o   <= ~strap_cfg;
			bus.cs_strobe_o <= 1'b1;
			bus.cs_par_lo_o <= 1'b1;
			bus.cs_par_hi_o <= 1'b1;
		end else begin
			unique case (st)
				RQ_IDLE: begin
					if (issue && issue_ready && bus.addr_strobe_n) begin
						st              <= RQ_ADDR;
						issue_ready     <= 1'b0;
						bus.cs_req_oe_n <= 1'b0;
						bus.cs_strobe_o <= 1'b0;
						bus.cs_addr_o   <= ~issue_addr;
						bus.cs_par_hi_o <= ~par_high(issue_addr);
						bus.cs_par_lo_o <= ~par_low(issue_addr);
					end else begin
						issue_ready     <= 1'b1;
						bus.cs_req_oe_n <= 1'b1;
						bus.cs_addr_o   <= '1;
					end
				end
				RQ_ADDR: begin
					st              <= RQ_TYPE;
					bus.cs_strobe_o <= 1'b1;
					bus.cs_addr_o   <= ~{1'b0, issue_type};
					bus.cs_par_hi_o <= 1'b1;
					bus.cs_par_lo_o <= 1'b1;
				end
				RQ_TYPE: begin
					st              <= RQ_IDLE;
					bus.cs_req_oe_n <= 1'b1;
					bus.cs_addr_o   <= '1;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- bench/sbr_bus_props.sv
`default_nettype none
module sbr_bus_props
	import sbr_pkg::*;
(
	input wire logic      core_clk,
	input wire logic      rst,
	input wire sbr_addr_t addr_n,
	input wire logic      addr_strobe_n,
	input wire logic      addr_parity_low_n,
	input wire logic      addr_parity_high_n,
	input wire logic      dev_req_oe_n,
	input wire logic      cs_req_oe_n,
	input wire logic      bus_error_n,
	input wire logic      bus_reset_n,
	input wire logic      target_ready_n
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Request phase
	// ------------------------------------------------------------
	AST_PAR_LOW: assert property (!addr_strobe_n |-> addr_parity_low_n == ~(^(~addr_n[23:3])))
		else $error("low parity wrong in strobe cycle");
	AST_PAR_HIGH: assert property (!addr_strobe_n |-> addr_parity_high_n == ~(^(~addr_n[35:24])))
		else $error("high parity wrong in strobe cycle");
	AST_TYPE_CYCLE: assert property (!addr_strobe_n && !dev_req_oe_n |=>
		addr_strobe_n && !dev_req_oe_n && addr_n[35] && addr_parity_low_n && addr_parity_high_n)
		else $error("type cycle does not follow address cycle");
	AST_RELEASE: assert property (!addr_strobe_n && !dev_req_oe_n |-> ##2 dev_req_oe_n)
		else $error("device holds lines after type cycle");
	AST_STROBE_ONE: assert property ($fell(addr_strobe_n) |=> $rose(addr_strobe_n))
		else $error("strobe longer than one cycle");
	AST_TARGET_READY_N: assert property (!addr_strobe_n && !dev_req_oe_n |->
		##3 !target_ready_n ##1 target_ready_n)
		else $error("target ready not three cycles after strobe");
	// Device config needs a stable strap window after reset
	AST_RST_HOLD: assert property ($fell(rst) |-> !bus_reset_n [*8])
		else $error("bus reset released too early");
	AST_STRAP_FREE: assert property ($rose(bus_reset_n) |=> cs_req_oe_n)
		else $error("straps still driven after bus reset");
	AST_BUS_ERROR_N_ONE: assert property ($fell(bus_error_n) |=> bus_error_n)
		else $error("bus error held longer than one cycle");
endmodule
`default_nettype wire

//--- bench/system_bus_request_phase_interface_tb.sv
`default_nettype none
module system_bus_request_phase_interface_tb
	import sbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic            core_clk = 0, rst = 1;
	logic            psel = 0, penable = 0, pwrite = 0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0, prdata, rdat;
	logic            pready, pslverr, irq, rerr;
	logic            internal_err = 0, req_error = 0;
	sbr_addr_t       lookup_addr_in = '0, lookup_addr, txn_addr, issue_addr = '0;
	sbr_addr_t       strap_cfg = 33'h1a5c31e2f;
	logic [3:0]      strap_ratio = 4'h9, core_ratio;
	logic            real_mode = 0, a20_gate = 0, issue = 0, bus_error_n_enable = 1;
	logic [31:0]     issue_type = 32'h0, txn_type;
	logic            issue_ready, txn_valid, txn_par_err, bus_error_seen, bus_in_reset;
	int              n_fail = 0, num_checks = 0;

	always #12.5 core_clk = ~core_clk;

	sbr_bus_if i_sbr_bus_if ();
	sbr_proc_end i_sbr_proc_end (.core_clk(core_clk), .rst(rst), .bus(i_sbr_bus_if),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.internal_err(internal_err), .req_error(req_error), .lookup_addr_in(lookup_addr_in),
		.lookup_addr(lookup_addr), .core_ratio(core_ratio), .bus_in_reset(bus_in_reset));
	sbr_cs_end i_sbr_cs_end (.core_clk(core_clk), .rst(rst), .bus(i_sbr_bus_if),
		.strap_cfg(strap_cfg), .strap_ratio(strap_ratio), .real_mode(real_mode),
		.a20_gate(a20_gate), .bus_error_n_enable(bus_error_n_enable), .issue(issue), .issue_addr(issue_addr),
		.issue_type(issue_type), .issue_ready(issue_ready), .txn_valid(txn_valid),
		.txn_addr(txn_addr), .txn_type(txn_type), .txn_par_err(txn_par_err),
		.bus_error_seen(bus_error_seen));
	sbr_bus_props i_sbr_bus_props (.core_clk(core_clk), .rst(rst),
		.addr_n(i_sbr_bus_if.addr_n), .addr_strobe_n(i_sbr_bus_if.addr_strobe_n),
		.addr_parity_low_n(i_sbr_bus_if.addr_parity_low_n),
		.addr_parity_high_n(i_sbr_bus_if.addr_parity_high_n),
		.dev_req_oe_n(i_sbr_bus_if.dev_req_oe_n), .cs_req_oe_n(i_sbr_bus_if.cs_req_oe_n),
		.bus_error_n(i_sbr_bus_if.bus_error_n), .bus_reset_n(i_sbr_bus_if.bus_reset_n),
		.target_ready_n(i_sbr_bus_if.target_ready_n));

	// ------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------
	task test_done;
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task tmo;
		n_fail++;
		$display("ERROR %0t: wait ran out", $time);
		test_done();
	endtask

	// Reply data is taken only at the edge where pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) tmo();
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task cs_issue(input sbr_addr_t a);
		int i;
		@(posedge core_clk);
		issue <= 1;
		issue_addr <= a;
		issue_type <= 32'h5;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (issue_ready === 1'b1) break;
		end
		if (i == 40) tmo();
		issue <= 0;
		repeat (8) @(posedge core_clk);
	endtask

	task dev_req;
		int i;
		apb(1, REG_CMD, 32'h1);
		for (i = 0; i < 30; i++) begin
			@(posedge core_clk);
			if (txn_valid === 1'b1) break;
		end
		if (i == 30) tmo();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task s_cfg;
		apb(0, REG_CFG_LO, 32'h0);
		chk(rdat, {strap_cfg[31:3], 3'b000});
		apb(0, REG_CFG_HI, 32'h0);
		chk(rdat, {20'h0, strap_ratio, 4'h0, strap_cfg[35:32]});
		chk(core_ratio, strap_ratio);
		apb(0, 8'h40, 32'h0);
		chk({rerr, rdat}, 33'h100000000);
		apb(1, REG_MASK, 32'h4);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b1);
		apb(0, REG_STATUS, 32'h0);
		chk(rdat[ST_CFG], 1'b1);
		repeat (3) @(posedge core_clk);
		chk(irq, 1'b0);
		apb(1, REG_MASK, 32'h0);
	endtask

	// Address bit 20 only survives when a20_gate is low
	task s_req(input logic gate);
		sbr_addr_t a, e;
		a = 33'h09f3a5e71;
		e = a;
		if (gate) e[20] = 1'b0;
		real_mode <= 1;
		a20_gate <= gate;
		cs_issue(33'h000001000);
		apb(0, REG_STATUS, 32'h0);
		chk(rdat[ST_SEEN], 1'b1);
		chk(rdat[ST_PARERR], 1'b0);
		lookup_addr_in <= '1;
		apb(1, REG_ADDR_LO, {a[31:3], 3'b000});
		apb(1, REG_ADDR_HI, {28'h0, a[35:32]});
		apb(1, REG_TYPE, 32'h8c3107e5);
		// The new mask level only arrives with the target ready of a device transaction
		dev_req();
		repeat (4) @(posedge core_clk);
		dev_req();
		chk(txn_addr, e);
		chk(txn_type, 32'h8c3107e5);
		chk(txn_par_err, 1'b0);
		chk(lookup_addr[20], !gate);
		apb(0, REG_STATUS, 32'h0);
		chk(rdat[ST_DONE], 1'b1);
	endtask

	task s_bus_error_n(input logic [2:0] ctrl, input logic ie, input logic re, input logic exp);
		logic seen;
		apb(1, REG_CTRL, {29'h0, ctrl});
		seen = 0;
		cs_issue(33'h000002000);
		// One-cycle error pulses keep the bus error line low for one cycle only
		internal_err <= ie;
		req_error <= re;
		@(posedge core_clk);
		internal_err <= 0;
		req_error <= 0;
		repeat (4) begin
			@(posedge core_clk);
			seen |= bus_error_seen;
		end
		chk(seen, exp);
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		int i;
		repeat (4) @(posedge core_clk);
		rst <= 0;
		for (i = 0; i < 60; i++) begin
			@(posedge core_clk);
			if (i == 1) chk(bus_in_reset, 1'b1);
			if (i_sbr_bus_if.bus_reset_n === 1'b1) break;
		end
		if (i == 60) tmo();
		repeat (4) @(posedge core_clk);
		chk(bus_in_reset, 1'b0);
		s_cfg();
		s_req(1'b1);
		s_req(1'b0);
		s_bus_error_n(3'h3, 1'b1, 1'b0, 1'b1);
		s_bus_error_n(3'h5, 1'b0, 1'b1, 1'b1);
		s_bus_error_n(3'h2, 1'b1, 1'b0, 1'b0);
		s_bus_error_n(3'h1, 1'b1, 1'b1, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
